// ### rtl/hp_slot_ctrl.sv
// Downstream slot hot-plug controller with Wishbone registers and expander link
//
// Summary of operation
// RULE1 - Controller runs only while capability enable set
// RULE2 - Enable rise or address write configures expander
// RULE3 - First sample after init sets no change flags
// RULE4 - Presence from expander or link, per select
// RULE5 - Read five inputs, drive four outputs via expander
// RULE6 - Slot reset only on general purpose pin
// RULE7 - Per-signal polarity invert, common to all ports
// RULE8 - Pulse mode holds interlock 100 to 150 ms
// RULE9 - Toggle mode inverts interlock per write
// RULE10 - Substitution: latch gives interlock status, latch closed
// RULE11 - Otherwise interlock status reads interlock output
// RULE12 - Auto power off when latch opens
// RULE13 - External logic holds fault until power toggled
// RULE14 - Configuration load never sets command completed
// RULE15 - Hot reset retrains link without presence change
// RULE16 - Inversion applied before compare and before drive
`timescale 1ns/1ps
`include "hp_regs.svh"
module hp_slot_ctrl #(
  parameter int unsigned ILOCK_PULSE_CYC = `ILOCK_CYC
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Wishbone slave
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        WE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  // Expander link
  input  wire logic        EXP_SCK_I,
  input  wire logic        EXP_MISO_I,
  output logic             EXP_SEL_O,
  output logic             EXP_MOSI_O,
  // Link and slot
  input  wire logic        LINK_UP_I,
  input  wire logic        HOT_RST_I,
  output logic             LINK_HOT_RST_O,
  output logic             SLOT_RST_N_O,
  output logic             IRQ_O
);

  localparam int CW = $clog2(ILOCK_PULSE_CYC + 1);

  // Refuse a pulse length the counter cannot serve
  if (ILOCK_PULSE_CYC < 1) begin : g_chk
    $error("ILOCK_PULSE_CYC must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic link_m, link_s, link_p;
  logic hrst_m, hrst_s, hrst_p;

  // Second and third stages feed edge logic
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      {link_p, link_s, link_m} <= 3'h0;
      {hrst_p, hrst_s, hrst_m} <= 3'h0;
    end else begin
      {link_p, link_s, link_m} <= {link_s, link_m, LINK_UP_I};
      {hrst_p, hrst_s, hrst_m} <= {hrst_s, hrst_m, HOT_RST_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic        acc, wr, rd;
  logic [31:0] wmask;
  logic [1:0]  cap_q;
  logic [2:0]  ctl_q;
  logic [12:0] cfg_q;
  logic [6:0]  addr_q;
  logic [4:0]  mask_q;
  logic [1:0]  gpio_q;
  logic [31:0] rd_data;
  logic [8:0]  sts_view;
  logic [4:0]  sts_q, sts_set;
  logic        ctl_wr, addr_wr, ilock_wr, sts_rd;

  assign acc      = CYC_I & STB_I & ~ACK_O;
  assign wr       = acc & WE_I;
  assign rd       = acc & ~WE_I;
  assign wmask    = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign ctl_wr   = wr & (ADR_I == `OFS_SLOT_CTL);
  assign addr_wr  = wr & (ADR_I == `OFS_EXP_ADDR) & SEL_I[0];
  assign ilock_wr = ctl_wr & SEL_I[0] & DAT_I[`CTL_ILOCK];
  assign sts_rd   = rd & (ADR_I == `OFS_SLOT_STS);

  // Byte-lane merge of write data into a stored value
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (DAT_I & wmask);
  endfunction

  // Writable registers; capability writes model the configuration load
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cap_q  <= `CAP_RST;
      ctl_q  <= `CTL_RST;
      cfg_q  <= `CFG_RST;
      addr_q <= `ADDR_RST;
      mask_q <= `MASK_RST;
      gpio_q <= `GPIO_RST_VAL;
    end else if (wr) begin
      case (ADR_I)
        `OFS_SLOT_CAP: cap_q  <= 2'(merge(32'(cap_q)));
        `OFS_SLOT_CTL: ctl_q  <= 3'(merge(32'(ctl_q)));
        `OFS_HP_CFG:   cfg_q  <= 13'(merge(32'(cfg_q)));
        `OFS_EXP_ADDR: addr_q <= 7'(merge(32'(addr_q)));
        `OFS_IRQ_MASK: mask_q <= 5'(merge(32'(mask_q)));
        `OFS_GPIO_CTL: gpio_q <= 2'(merge(32'(gpio_q)));
        default:       ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (ADR_I)
      `OFS_SLOT_CAP: rd_data = 32'(cap_q);
      `OFS_SLOT_CTL: rd_data = 32'(ctl_q);
      `OFS_SLOT_STS: rd_data = 32'(sts_view);
      `OFS_HP_CFG:   rd_data = 32'(cfg_q);
      `OFS_EXP_ADDR: rd_data = 32'(addr_q);
      `OFS_IRQ_MASK: rd_data = 32'(mask_q);
      `OFS_GPIO_CTL: rd_data = 32'(gpio_q);
      default:       rd_data = 32'h00000000;
    endcase
  end

  // One registered answer per request, a cycle after it; ack drops the cycle after
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= acc;
      if (rd) begin
        DAT_O <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expander sequencing

  hp_pkg::seq_state_t state_q;
  logic               en_p_q, init_pend_q, first_q, start_q;
  logic               frame_done;
  logic [7:0]         rx;
  logic [3:0]         out_lvl;
  logic [7:0]         tx;
  logic               pwr_en_q, ilock_q;
  hp_pkg::in_vec_t    smp, in_q;
  logic               poll_done;

  // Inputs are inverted before anything compares them [RULE16] [RULE7]
  assign smp       = rx[4:0] ^ cfg_q[`CFG_INV_LSB +: 5];
  // Outputs are inverted on their way to the expander [RULE16] [RULE7]
  assign out_lvl   = {ilock_q, pwr_en_q, ctl_q[`CTL_PIND], ctl_q[`CTL_ATTN]}
                     ^ cfg_q[`CFG_INV_OUT +: 4];
  // Configuration frame sets pin directions; poll frames carry outputs [RULE5]
  assign tx        = (state_q == hp_pkg::ST_CFG) ? `EXP_DIR_MASK : {4'h0, out_lvl};
  assign poll_done = frame_done & (state_q == hp_pkg::ST_POLL);

  // Enable edge and address write request a fresh initialisation
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en_p_q      <= 1'b0;
      init_pend_q <= 1'b0;
    end else begin
      en_p_q <= cap_q[`CAP_ENABLE];
      if ((cap_q[`CAP_ENABLE] & ~en_p_q) | (addr_wr & cap_q[`CAP_ENABLE])) begin
        init_pend_q <= 1'b1; // [RULE2]
      end else if (state_q != hp_pkg::ST_CFG && start_q) begin
        init_pend_q <= init_pend_q;
      end else if (state_q == hp_pkg::ST_CFG) begin
        init_pend_q <= 1'b0;
      end
    end
  end

  // Sequencer; a pending init waits for the frame in flight to end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= hp_pkg::ST_OFF;
      start_q <= 1'b0;
      first_q <= 1'b0;
    end else if (!cap_q[`CAP_ENABLE]) begin
      state_q <= hp_pkg::ST_OFF; // [RULE1]
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        hp_pkg::ST_OFF, hp_pkg::ST_GAP: begin
          if (init_pend_q) begin
            state_q <= hp_pkg::ST_CFG; // [RULE2]
            first_q <= 1'b1; // [RULE3]
            start_q <= 1'b1;
          end else if (state_q == hp_pkg::ST_GAP) begin
            state_q <= hp_pkg::ST_POLL;
            start_q <= 1'b1;
          end
        end
        hp_pkg::ST_CFG: begin
          if (frame_done) begin
            state_q <= hp_pkg::ST_GAP;
          end
        end
        hp_pkg::ST_POLL: begin
          if (frame_done) begin
            state_q <= hp_pkg::ST_GAP;
            first_q <= 1'b0;
          end
        end
        default: state_q <= hp_pkg::ST_OFF;
      endcase
    end
  end

  // Frame engine on the sampled link clock
  exp_link u_link (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .start_i(start_q),
    .cfg_i  (state_q == hp_pkg::ST_CFG),
    .addr_i (addr_q),
    .tx_i   (tx),
    .done_o (frame_done),
    .rx_o   (rx),
    .sck_i  (EXP_SCK_I),
    .miso_i (EXP_MISO_I),
    .sel_o  (EXP_SEL_O),
    .mosi_o (EXP_MOSI_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slot state and outputs

  logic [CW-1:0] ilock_cnt_q;
  logic          cmd_pend_q, hr_sup_q;
  logic          latch_open, subst, pres_now;

  assign subst      = cfg_q[`CFG_SUBST];
  assign latch_open = in_q[3];
  assign pres_now   = cfg_q[`CFG_PSRC] ? link_s : in_q[1]; // [RULE4]

  // Latest samples; fault is not held here, the slot side holds it [RULE13]
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      in_q <= 5'h00;
    end else if (poll_done) begin
      in_q <= smp;
    end
  end

  // Latch opening overrides the power controller bit [RULE12]
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pwr_en_q <= 1'b0;
    end else begin
      pwr_en_q <= ~ctl_q[`CTL_PCC] &
                  ~(cfg_q[`CFG_AUTOOFF] & cap_q[`CAP_LATCH] & latch_open);
    end
  end

  // Interlock: timed pulse, or level flip in toggle mode
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ilock_q     <= 1'b0;
      ilock_cnt_q <= '0;
    end else if (ilock_wr && cfg_q[`CFG_TOGGLE]) begin
      ilock_q     <= ~ilock_q; // [RULE9]
      ilock_cnt_q <= '0;
    end else if (ilock_wr) begin
      ilock_q     <= 1'b1; // [RULE8]
      ilock_cnt_q <= CW'(ILOCK_PULSE_CYC);
    end else if (ilock_cnt_q != '0) begin
      ilock_cnt_q <= ilock_cnt_q - 1'b1;
      if (ilock_cnt_q == CW'(1)) begin
        ilock_q <= 1'b0; // [RULE8]
      end
    end
  end

  // Hot reset drives the link and masks in-band presence until it retrains
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      hr_sup_q       <= 1'b0;
      LINK_HOT_RST_O <= 1'b0;
    end else begin
      LINK_HOT_RST_O <= hrst_s; // [RULE15]
      if (hrst_s & ~hrst_p) begin
        hr_sup_q <= 1'b1; // [RULE15]
      end else if (!hrst_s && link_s && !link_p) begin
        hr_sup_q <= 1'b0;
      end
    end
  end

  // Only software control writes await completion, never loads [RULE14]
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cmd_pend_q <= 1'b0;
    end else if (ctl_wr) begin
      cmd_pend_q <= 1'b1;
    end else if (poll_done) begin
      cmd_pend_q <= 1'b0;
    end
  end

  // Events; the initial sample compares nothing [RULE3]
  always_comb begin
    sts_set = 5'h00;
    if (poll_done && !first_q) begin
      sts_set[`STS_ABP] = smp[0] & ~in_q[0];
      sts_set[`STS_PFD] = smp[2] & ~in_q[2];
      sts_set[`STS_LSC] = (smp[3] ^ in_q[3]) & ~subst;
      sts_set[`STS_PDC] = (smp[1] ^ in_q[1]) & ~cfg_q[`CFG_PSRC]; // [RULE4]
    end
    if (cfg_q[`CFG_PSRC] && (link_s ^ link_p) && !hr_sup_q && !first_q) begin
      sts_set[`STS_PDC] = 1'b1; // [RULE15]
    end
    sts_set[`STS_CC] = poll_done & cmd_pend_q; // [RULE14]
  end

  // Sticky status; a read clears, a same-cycle event still lands
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sts_q <= 5'h00;
    end else begin
      sts_q <= (sts_q & ~{5{sts_rd}}) | sts_set;
    end
  end

  // Live view: substitution reports the latch as interlock state [RULE10] [RULE11]
  assign sts_view = {in_q[4], subst ? in_q[3] : ilock_q, pres_now,
                     subst ? 1'b0 : in_q[3], sts_q};

  // Level interrupt, GPIO reset pin, kept off the expander [RULE6]
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_O        <= 1'b0;
      SLOT_RST_N_O <= 1'b1;
    end else begin
      IRQ_O        <= |(sts_q & mask_q);
      SLOT_RST_N_O <= ~(gpio_q[`GPIO_ALT] & gpio_q[`GPIO_RST]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic [CW-1:0] hi_cnt_q;

  // Length of the current interlock high phase
  always_ff @(posedge CLK_I) begin
    if (RST_I || !ilock_q) begin
      hi_cnt_q <= '0;
    end else begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end
  end

  a_idle_when_off: assert property ( // [RULE1]
    !cap_q[`CAP_ENABLE] |=> state_q == hp_pkg::ST_OFF && !start_q)
    else $error("controller active while disabled");
  a_enable_starts_init: assert property ( // [RULE2]
    cap_q[`CAP_ENABLE] && !en_p_q |-> ##[1:400] state_q == hp_pkg::ST_CFG)
    else $error("enable did not start initialisation");
  a_first_sample_quiet: assert property ( // [RULE3]
    poll_done && first_q |=> !$rose(sts_q[`STS_LSC]) && !$rose(sts_q[`STS_PDC]))
    else $error("initial sample set a change flag");
  a_sample_inverted: assert property ( // [RULE16]
    poll_done |=> in_q == ($past(rx[4:0]) ^ $past(cfg_q[4:0])))
    else $error("sample stored without polarity inversion");
  a_reset_pin_idle: assert property ( // [RULE6]
    !gpio_q[`GPIO_ALT] |=> SLOT_RST_N_O)
    else $error("slot reset driven without alternate function");
  a_pulse_length: assert property ( // [RULE8]
    $fell(ilock_q) && ilock_cnt_q == '0 && !$past(ilock_wr) |->
      $past(hi_cnt_q) == CW'(ILOCK_PULSE_CYC - 1))
    else $error("interlock pulse length wrong");
  a_toggle_flips: assert property ( // [RULE9]
    ilock_wr && cfg_q[`CFG_TOGGLE] |=> ilock_q != $past(ilock_q))
    else $error("toggle write did not flip interlock");
  a_latch_subst: assert property ( // [RULE10]
    sts_rd && subst |=> DAT_O[`STS_EIS] == $past(in_q[3]) && !DAT_O[`STS_LSS])
    else $error("substitution status wrong");
  a_interlock_status: assert property ( // [RULE11]
    sts_rd && !subst |=> DAT_O[`STS_EIS] == $past(ilock_q))
    else $error("interlock status not the output level");
  a_auto_power_off: assert property ( // [RULE12]
    cfg_q[`CFG_AUTOOFF] && cap_q[`CAP_LATCH] && latch_open |=> !pwr_en_q)
    else $error("slot power on with latch open");
  a_cc_by_command: assert property ( // [RULE14]
    $rose(sts_q[`STS_CC]) |-> $past(cmd_pend_q) && $past(poll_done))
    else $error("command completed without a command");
  a_hot_reset_quiet: assert property ( // [RULE15]
    hr_sup_q && cfg_q[`CFG_PSRC] |=> !$rose(sts_q[`STS_PDC]))
    else $error("presence change during hot reset");

  c_init_done: cover property (state_q == hp_pkg::ST_CFG ##[1:400] poll_done);
  c_pulse_ends: cover property ($fell(ilock_q));
  c_irq_raised: cover property ($rose(IRQ_O));

endmodule

// ### rtl/hp_regs.svh
// Register offsets, field positions, reset values and timing for the slot controller
`ifndef HP_REGS_SVH
`define HP_REGS_SVH

// Byte offsets on the register bus
`define OFS_SLOT_CAP   8'h00
`define OFS_SLOT_CTL   8'h04
`define OFS_SLOT_STS   8'h08
`define OFS_HP_CFG     8'h0C
`define OFS_EXP_ADDR   8'h10
`define OFS_IRQ_MASK   8'h14
`define OFS_GPIO_CTL   8'h18

// Slot capabilities fields
`define CAP_ENABLE     0
`define CAP_LATCH      1

// Slot control fields
`define CTL_ATTN       0
`define CTL_PIND       1
`define CTL_PCC        2
`define CTL_ILOCK      3

// Slot status fields (bits 4:0 sticky)
`define STS_ABP        0
`define STS_PFD        1
`define STS_LSC        2
`define STS_PDC        3
`define STS_CC         4
`define STS_LSS        5
`define STS_PDS        6
`define STS_EIS        7
`define STS_PGD        8

// Hot-plug configuration fields
`define CFG_INV_LSB    0
`define CFG_INV_OUT    5
`define CFG_PSRC       9
`define CFG_TOGGLE     10
`define CFG_SUBST      11
`define CFG_AUTOOFF    12

// General purpose pin control fields
`define GPIO_ALT       0
`define GPIO_RST       1

// Reset values
`define CAP_RST        2'h0
`define CTL_RST        3'h4
`define CFG_RST        13'h0000
`define ADDR_RST       7'h20
`define MASK_RST       5'h00
`define GPIO_RST_VAL   2'h0

// Expander frame layout
`define EXP_DIR_MASK   8'h1F
`define FRAME_BITS     16

// Interlock pulse timing
`define CLK_KHZ        100000
`define ILOCK_MIN_MS   100
`define ILOCK_MAX_MS   150
`define ILOCK_CYC      (((`ILOCK_MIN_MS + `ILOCK_MAX_MS) / 2) * `CLK_KHZ)

`endif

// ### rtl/hp_pkg.sv
// Types shared by the slot controller files
package hp_pkg;

  // Expander sequencing states, Gray along OFF-CFG-POLL-GAP
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_CFG  = 2'b01,
    ST_POLL = 2'b11,
    ST_GAP  = 2'b10
  } seq_state_t;

  // Expander input sample: button, presence, fault, latch, power good
  typedef logic [4:0] in_vec_t;

endpackage

// ### rtl/exp_link.sv
// Serial frame engine toward the slot I/O expander, timed by the sampled link clock
`timescale 1ns/1ps
`include "hp_regs.svh"
module exp_link (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Frame request
  input  wire logic       start_i,
  input  wire logic       cfg_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] tx_i,
  // Frame result
  output logic            done_o,
  output logic [7:0]      rx_o,
  // Expander pins
  input  wire logic       sck_i,
  input  wire logic       miso_i,
  output logic            sel_o,
  output logic            mosi_o
);

  logic        sck_m, sck_s, sck_p;
  logic        miso_m, miso_s;
  logic        busy_q;
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic        sck_rise, sck_fall;

  // Two flops on each pin, a third on the clock; the edge detector compares the second and third stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sck_p, sck_s, sck_m} <= 3'h0;
      {miso_s, miso_m}      <= 2'h0;
    end else begin
      {sck_p, sck_s, sck_m} <= {sck_s, sck_m, sck_i};
      {miso_s, miso_m}      <= {miso_m, miso_i};
    end
  end

  assign sck_rise = sck_s & ~sck_p;
  assign sck_fall = ~sck_s & sck_p;

  // Shift out on falling link edges, sample on rising ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      sel_o  <= 1'b0;
      mosi_o <= 1'b0;
      sh_q   <= 16'h0000;
      cnt_q  <= 5'h00;
      rx_o   <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_q && start_i) begin
        busy_q <= 1'b1;
        sel_o  <= 1'b1;
        sh_q   <= {addr_i, cfg_i, tx_i};
        mosi_o <= addr_i[6];
        cnt_q  <= 5'h00;
      end else if (busy_q) begin
        if (sck_rise) begin
          rx_o  <= {rx_o[6:0], miso_s};
          cnt_q <= cnt_q + 5'h01;
        end else if (sck_fall) begin
          if (cnt_q == 5'(`FRAME_BITS)) begin
            busy_q <= 1'b0;
            sel_o  <= 1'b0;
            done_o <= 1'b1;
          end else if (cnt_q != 5'h00) begin
            sh_q   <= {sh_q[14:0], 1'b0};
            mosi_o <= sh_q[14];
          end
        end
      end
    end
  end

endmodule

// ### test/exp_model.sv
// Behavioural slot I/O expander answering the controller's serial frames
`timescale 1ns/1ps
module exp_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Serial link
  input  wire logic       sck_i,
  input  wire logic       sel_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // Slot side
  input  wire logic [7:0] pins_i,
  input  wire logic       fault_set_i,
  output logic [7:0]      out_o,
  output logic [7:0]      dir_o,
  output logic [6:0]      addr_o
);
  logic [2:0]  sck_s;
  logic        sel_q;
  logic        fault_q;
  logic [4:0]  cnt;
  logic [15:0] sh;
  logic [7:0]  pins;

  ////////////////////////////////////////////////////////////////////////////////
  // Edges found as the master finds them, so both sides count the same bits
  always_ff @(posedge clk_i) begin
    sck_s <= {sck_s[1:0], sck_i};
    sel_q <= sel_i;
    if (rst_i || !sel_i) begin
      cnt <= 5'h00;
    end else if (sck_s[1] && !sck_s[2]) begin
      sh  <= {sh[14:0], mosi_i};
      cnt <= cnt + 5'h01;
    end
    // Outside the input byte the line scrambles, so a stale level never reads as data
    if (rst_i) begin
      miso_o <= 1'b0;
    end else if (sck_s[2] && !sck_s[1]) begin
      miso_o <= (sel_i && cnt[4:3] == 2'b01) ? pins[4'hF - {1'b1, cnt[2:0]}] : ~miso_o;
    end
    // Frame end: configuration frames set direction, polls set the outputs
    if (rst_i) begin
      out_o  <= 8'h00;
      dir_o  <= 8'h00;
      addr_o <= 7'h00;
    end else if (sel_q && !sel_i && sh[8]) begin
      dir_o  <= sh[7:0];
      addr_o <= sh[15:9];
    end else if (sel_q && !sel_i) begin
      out_o <= sh[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slot logic holds a fault until the power enable output moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (fault_set_i) begin
      fault_q <= 1'b1;
    end else if (sel_q && !sel_i && !sh[8] && sh[2] != out_o[2]) begin
      fault_q <= 1'b0;
    end
  end
  assign pins = {pins_i[7:3], pins_i[2] | fault_q, pins_i[1:0]};
endmodule

// ### test/hp_slot_ctrl_tb.sv
// Self-checking bench for the slot hot-plug controller and its expander
`timescale 1ns/1ps
module hp_slot_ctrl_tb;
  localparam int unsigned PULSE = 2000; // Short interlock pulse keeps the run brief
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sck = 1'b0;
  logic        link_up = 1'b1, hot_rst = 1'b0, fault_set = 1'b0;
  logic        ack, exp_sel, mosi, miso, hot_rst_o, slot_rst_n, irq;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00, pins = 8'h00, out_b, dir_b;
  logic [6:0]  exp_adr;
  logic [31:0] wdat = 32'h0, rdata, dat;
  int          failures = 0, check_count = 0, cycles = 0, w;
  time         t0;

  hp_slot_ctrl #(.ILOCK_PULSE_CYC(PULSE)) dut_u (.CLK_I(clk), .RST_I(rst), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdata),
    .ACK_O(ack), .EXP_SCK_I(sck), .EXP_MISO_I(miso), .EXP_SEL_O(exp_sel),
    .EXP_MOSI_O(mosi), .LINK_UP_I(link_up), .HOT_RST_I(hot_rst),
    .LINK_HOT_RST_O(hot_rst_o), .SLOT_RST_N_O(slot_rst_n), .IRQ_O(irq));
  exp_model exp_u (.clk_i(clk), .rst_i(rst), .sck_i(sck), .sel_i(exp_sel), .mosi_i(mosi),
    .miso_o(miso), .pins_i(pins), .fault_set_i(fault_set), .out_o(out_b), .dir_o(dir_b),
    .addr_o(exp_adr));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock, and a free running link clock of unrelated phase
  always #5 clk = ~clk;
  initial begin
    #13;
    forever #40 sck = ~sck;
  end
  // Hang guard: the run needs well under half of this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  // Classic cycle: request held until ack is sampled, then released for a cycle
  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    dat = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    bus(1'b0, a, 32'h0);
    check(dat & m, e, what);
  endtask
  // Waits whole frames; a few cycles more let status and interrupt settle
  task automatic frames(input int n);
    repeat (n) @(negedge exp_sel);
    repeat (4) @(posedge clk);
  endtask
  task automatic idle(input string what);
    int k;
    k = 0;
    repeat (300) begin
      @(posedge clk);
      if (exp_sel !== 1'b0) k++;
    end
    check(k, 0, what);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] val [7] = '{32'h0, 32'h4, 32'h0, 32'h20, 32'h0, 32'h0, 32'h0};
    wr(8'h1C, 32'hFFFFFFFF);
    foreach (ofs[i]) rd(ofs[i], 32'hFFFFFFFF, val[i], "reset value");
    check({slot_rst_n, irq}, 2'b10, "pins after reset");
    idle("no frames while disabled");
    $display("Test reset finished");
  endtask
  task automatic t_init();
    pins <= 8'h12;
    wr(8'h00, 32'h3);
    frames(3);
    check({exp_adr, dir_b}, {7'h20, 8'h1F}, "config frame");
    rd(8'h08, 32'h1FF, 32'h140, "first sample");
    wr(8'h10, 32'h27);
    wait (exp_adr === 7'h27);
    pins <= 8'h10;
    frames(2);
    rd(8'h08, 32'h1FF, 32'h100, "sample after new address");
    $display("Test init finished");
  endtask
  task automatic t_irq();
    wr(8'h14, 32'h08);
    pins <= 8'h13;
    frames(2);
    check(irq, 1'b1, "irq raised");
    rd(8'h08, 32'h1FF, 32'h149, "presence change");
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "irq cleared by read");
    wr(8'h14, 32'h00);
    pins <= 8'h10;
    frames(2);
    check(irq, 1'b0, "masked change");
    rd(8'h08, 32'h1FF, 32'h108, "flag under mask");
    $display("Test interrupt finished");
  endtask
  task automatic t_out();
    pins <= 8'h12;
    wr(8'h04, 32'h3);
    frames(2);
    check(out_b[3:0], 4'h7, "expander outputs");
    rd(8'h08, 32'h1FF, 32'h158, "command done");
    fault_set <= 1'b1;
    @(posedge clk);
    fault_set <= 1'b0;
    frames(2);
    rd(8'h08, 32'h2, 32'h2, "power fault");
    wr(8'h04, 32'h7);
    frames(2);
    wr(8'h0C, 32'h1E2);
    frames(2);
    check(out_b[3:0], 4'hC, "inverted outputs");
    rd(8'h08, 32'h48, 32'h08, "inverted presence");
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h3);
    frames(2);
    bus(1'b0, 8'h08, 32'h0);
    $display("Test outputs finished");
  endtask
  task automatic t_ilock();
    wr(8'h04, 32'hB);
    wait (out_b[3] === 1'b1);
    t0 = $time;
    rd(8'h08, 32'h80, 32'h80, "interlock status high");
    wait (out_b[3] === 1'b0);
    w = int'(($time - t0) / 10);
    check(w > PULSE - 300 && w < PULSE + 300, 1'b1, "pulse width");
    rd(8'h08, 32'h80, 32'h00, "interlock status low");
    wr(8'h0C, 32'h400);
    wr(8'h04, 32'hB);
    frames(2);
    rd(8'h08, 32'h80, 32'h80, "toggled on");
    wr(8'h04, 32'hB);
    frames(2);
    rd(8'h08, 32'h80, 32'h00, "toggled off");
    $display("Test interlock finished");
  endtask
  task automatic t_latch();
    wr(8'h0C, 32'h800);
    pins <= 8'h1A;
    frames(2);
    rd(8'h08, 32'hA4, 32'h80, "latch as interlock");
    pins <= 8'h12;
    frames(2);
    rd(8'h08, 32'hA4, 32'h00, "latch closed");
    wr(8'h0C, 32'h1000);
    pins <= 8'h1A;
    frames(2);
    check(out_b[2], 1'b0, "power removed");
    rd(8'h08, 32'h24, 32'h24, "latch open");
    pins <= 8'h12;
    $display("Test latch finished");
  endtask
  task automatic t_link();
    wr(8'h0C, 32'h200);
    link_up <= 1'b0;
    frames(2);
    bus(1'b0, 8'h08, 32'h0);
    rd(8'h08, 32'h48, 32'h00, "link down, card pin present");
    link_up <= 1'b1;
    frames(2);
    rd(8'h08, 32'h48, 32'h48, "link up");
    hot_rst <= 1'b1;
    repeat (6) @(posedge clk);
    check(hot_rst_o, 1'b1, "link in hot reset");
    link_up <= 1'b0;
    frames(2);
    hot_rst <= 1'b0;
    repeat (6) @(posedge clk);
    check(hot_rst_o, 1'b0, "hot reset over");
    link_up <= 1'b1;
    frames(2);
    rd(8'h08, 32'h48, 32'h40, "retrain, no change flag");
    $display("Test link finished");
  endtask
  task automatic t_gpio();
    logic [7:0] ob;
    ob = out_b;
    wr(8'h18, 32'h3);
    repeat (2) @(posedge clk);
    check(slot_rst_n, 1'b0, "slot reset on pin");
    frames(2);
    check(out_b, ob, "expander untouched");
    wr(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    check(slot_rst_n, 1'b1, "slot reset released");
    wr(8'h00, 32'h0);
    repeat (200) @(posedge clk);
    idle("link stops when disabled");
    $display("Test gpio finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_init();
    t_irq();
    t_out();
    t_ilock();
    t_latch();
    t_link();
    t_gpio();
    tally_and_finish();
  end
endmodule
